// [pkg/irqc_regs.vh]
/*
 * constants of the interrupt request block: option register address,
 * field positions, reset value, vector addresses and context codes.
 * assumes the includer keeps widths as given here.
 */
`ifndef IRQC_REGS_VH
`define IRQC_REGS_VH

// option register, byte address on the register port
`define IRQC_OPT_ADDR 8'hC8
// option register reset value
`define IRQC_OPT_RST 8'h00
// writable bits of the option register
`define IRQC_OPT_WMASK 8'h70
// field positions
`define IRQC_LES_BIT 6
`define IRQC_ESB_BIT 5
`define IRQC_GEN_BIT 4

// vector addresses, source 0 to 4
`define IRQC_VEC0 12'hFFC
`define IRQC_VEC1 12'hFF6
`define IRQC_VEC2 12'hFF4
`define IRQC_VEC3 12'hFF2
`define IRQC_VEC4 12'hFF0

// context codes, also flag set selectors
`define IRQC_CTX_NORM 2'h0
`define IRQC_CTX_IRQ 2'h1
`define IRQC_CTX_NMI 2'h2

`endif

// [logic/irqc_edge_latch.v]
/*
 * edge capture latch for one request line.
 * assumes line is already synchronous to ref_clk.
 */
`default_nettype none
`include "irqc_regs.vh"

module irqc_edge_latch (
	// clock and reset
	input wire ref_clk,
	input wire rstn,
	// line and control
	input wire line,
	input wire rise_sel,
	input wire clr,
	// captured request
	output reg pend_r
);

	reg line_d_r; // previous line level
	wire edge_hit; // selected edge seen

	assign edge_hit = rise_sel ? (line & ~line_d_r) : (~line & line_d_r);

	// one stored request, set wins over clear
	always @(posedge ref_clk) begin
		if (!rstn) begin
			line_d_r <= 1'b1;
			pend_r <= 1'b0;
		end else begin
			line_d_r <= line;
			if (edge_hit)
				pend_r <= 1'b1;
			else if (clr)
				pend_r <= 1'b0;
		end
	end

endmodule // irqc_edge_latch
`default_nettype wire

// [logic/irqc_flag_bank.v]
/*
 * three banked carry and zero flag pairs: normal, interrupt, nmi.
 * assumes sel is a valid context code from the header.
 */
`default_nettype none
`include "irqc_regs.vh"

module irqc_flag_bank (
	// clock and reset
	input wire ref_clk,
	input wire rstn,
	// selection and write port
	input wire [1:0] sel,
	input wire wr,
	input wire c_in,
	input wire z_in,
	// selected pair, registered
	output reg c_r,
	output reg z_r
);

	reg [2:0] c_set_r; // carry per context
	reg [2:0] z_set_r; // zero per context

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_set
			// write only the selected pair
			always @(posedge ref_clk) begin
				if (!rstn) begin
					c_set_r[g] <= 1'b0;
					z_set_r[g] <= 1'b0;
				end else if (wr && sel == g) begin
					c_set_r[g] <= c_in;
					z_set_r[g] <= z_in;
				end
			end
		end
	endgenerate

	// read side lags selection by one cycle
	always @(posedge ref_clk) begin
		if (!rstn) begin
			c_r <= 1'b0;
			z_r <= 1'b0;
		end else begin
			c_r <= (sel == 2'h3) ? 1'b0 : c_set_r[sel];
			z_r <= (sel == 2'h3) ? 1'b0 : z_set_r[sel];
		end
	end

endmodule // irqc_flag_bank
`default_nettype wire

// [logic/irqc_top.v]
/*
 * interrupt request logic: one nmi source and four fixed priority
 * maskable sources, option register, entry and return sequencing
 * and banked flags. assumes the core pulses core_boundary at each
 * instruction end and return_from_interrupt on the return opcode.
 */
// The strobed register port was chosen for this implementation.
// Functional notes
// R01: cleared enable blocks maskable, never nmi
// R02: nmi serviced but no wake without enable
// R03: nmi latched, cleared at routine start
// R04: option bit 6: source 1 level/falling
// R05: source 2 edge, bit 5 picks polarity
// R06: sources 3 and 4 level only
// R07: edge latch keeps one request until start
// R08: level requester holds line until sampled
// R09: sample requests at each instruction boundary
// R10: three banked carry/zero flag sets
// R11: entry: swap, push, inhibit, clear, vector
// R12: return restores flags and pops counter
// R13: ldi anomaly: mode switches, flags do not
// R14: option register write only, full byte
// R15: option bit 4 is global enable
// R16: timer and converter events onto vector 4
// R17: reload timer events onto vector 3
// R18: serial event onto vector 2 with port C
// R19: ports A,B on vector 1, C on 2
// R20: fixed priority, no maskable preemption
// R21: nmi may preempt any routine (code: maskable routines only, a pending nmi waits while in nmi)
// R22: pending flag plus highest index output
`default_nettype none
`include "irqc_regs.vh"

module irqc_top (
	// clock and reset
	input wire ref_clk,
	input wire rstn,
	// register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata_r,
	// pins, asynchronous, active low
	input wire nmi_pin_n,
	input wire [7:0] pa_pin,
	input wire [7:0] pb_pin,
	input wire [7:0] pc_pin,
	// port option and data bits
	input wire [7:0] pa_opt,
	input wire [7:0] pa_dat,
	input wire [7:0] pb_opt,
	input wire [7:0] pb_dat,
	input wire [7:0] pc_opt,
	input wire [7:0] pc_dat,
	// peripheral events and masks
	input wire timer_zero_flag,
	input wire timer_irq_mask,
	input wire conv_done_flag,
	input wire converter_irq_mask,
	input wire reload_overflow_flag,
	input wire reload_overflow_irq_mask,
	input wire reload_compare_flag,
	input wire reload_compare_irq_mask,
	input wire reload_edge_flag,
	input wire reload_edge_irq_mask,
	input wire serial_running_flag,
	input wire serial_irq_mask,
	// core handshake
	input wire core_boundary,
	input wire return_from_interrupt,
	input wire ldi_opt_window,
	input wire flag_wr,
	input wire flag_c_in,
	input wire flag_z_in,
	// answers to the core
	output reg irq_pending_r,
	output reg [2:0] irq_index_r,
	output reg wake_r,
	output reg flag_swap_r,
	output reg pc_push_r,
	output reg pc_pop_r,
	output reg vec_load_r,
	output reg [11:0] vec_addr_r,
	output reg [1:0] irq_mode_r,
	output wire carry_r,
	output wire zero_r
);

	// entry sequence states
	localparam ST_IDLE = 3'h0;
	localparam ST_SWAP = 3'h1;
	localparam ST_PUSH = 3'h2;
	localparam ST_INHB = 3'h3;
	localparam ST_CLRL = 3'h4;
	localparam ST_VECT = 3'h5;

	// option register and fields
	reg [7:0] interrupt_option_reg_r;
	wire global_irq_enable;
	wire src1_level_select;
	wire src2_edge_polarity;

	// pin synchronisers, first stage read by second only
	reg [24:0] pin_s1_r;
	reg [24:0] pin_s2_r;
	wire [24:0] pin_raw;

	// source lines
	wire [7:0] pa_act; // port A pin requesting
	wire [7:0] pb_act; // port B pin requesting
	wire [7:0] pc_act; // port C pin requesting
	wire src1_req; // source 1 level, high active
	wire src2_req; // source 2 level, high active
	wire src3_req; // source 3 level
	wire src4_req; // source 4 level
	wire nmi_pend; // captured nmi
	wire src1_pend; // captured source 1 edge
	wire src2_pend; // captured source 2 edge
	wire src1_any; // source 1 after mode choice

	// sequencing state
	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg [2:0] take_idx_r; // source being entered
	reg anomaly_r; // flag swap suppressed
	reg inhib_r; // maskable lines inhibited
	reg [1:0] flag_sel_r; // active flag set
	reg [1:0] nmi_ret_mode_r; // context under nmi
	reg [1:0] nmi_ret_sel_r; // flag set under nmi
	reg [2:0] clr_r; // latch clear pulses

	// arbitration
	reg req_any; // something may be taken
	reg [2:0] req_idx; // winning index
	reg mask_ok; // maskable allowed now
	reg [11:0] vec_sel; // vector of take_idx_r

	// option fields, R15 global enable
	assign global_irq_enable = interrupt_option_reg_r[`IRQC_GEN_BIT];
	assign src1_level_select = interrupt_option_reg_r[`IRQC_LES_BIT];
	assign src2_edge_polarity = interrupt_option_reg_r[`IRQC_ESB_BIT];

	// R14 full-byte write only
	always @(posedge ref_clk) begin
		if (!rstn)
			interrupt_option_reg_r <= `IRQC_OPT_RST;
		else if (reg_wr && reg_addr == `IRQC_OPT_ADDR)
			interrupt_option_reg_r <= reg_wdata & `IRQC_OPT_WMASK;
	end

	// reads of any address answer zero, register is write only
	always @(posedge ref_clk) begin
		if (!rstn)
			reg_rdata_r <= 8'h00;
		else if (reg_rd)
			reg_rdata_r <= 8'h00;
	end

	// gather pins for one synchroniser bank
	assign pin_raw = {nmi_pin_n, pc_pin, pb_pin, pa_pin};

	// two flops per pin
	genvar g;
	generate
		for (g = 0; g < 25; g = g + 1) begin : g_sync
			always @(posedge ref_clk) begin
				if (!rstn) begin
					pin_s1_r[g] <= 1'b1;
					pin_s2_r[g] <= 1'b1;
				end else begin
					pin_s1_r[g] <= pin_raw[g];
					pin_s2_r[g] <= pin_s1_r[g];
				end
			end
		end
	endgenerate

	// R19 pins low and enabled by option and data
	assign pa_act = ~pin_s2_r[7:0] & pa_opt & pa_dat;
	assign pb_act = ~pin_s2_r[15:8] & pb_opt & pb_dat;
	assign pc_act = ~pin_s2_r[23:16] & pc_opt & pc_dat;
	assign src1_req = (|pa_act) | (|pb_act);

	// R18 serial end with port C on vector 2
	assign src2_req = (|pc_act) | (serial_running_flag & serial_irq_mask);

	// R17 reload timer events on vector 3
	assign src3_req = (reload_overflow_flag & reload_overflow_irq_mask) |
		(reload_compare_flag & reload_compare_irq_mask) |
		(reload_edge_flag & reload_edge_irq_mask);

	// R16 timer and converter on vector 4
	assign src4_req = (timer_zero_flag & timer_irq_mask) |
		(conv_done_flag & converter_irq_mask);

	// R03 nmi captured on falling pin edge
	irqc_edge_latch u_nmi (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.line(pin_s2_r[24]),
		.rise_sel(1'b0),
		.clr(clr_r[0]),
		.pend_r(nmi_pend)
	);

	// R04 source 1 falling edge when level mode off
	irqc_edge_latch u_src1 (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.line(~src1_req),
		.rise_sel(1'b0),
		.clr(clr_r[1] | src1_level_select),
		.pend_r(src1_pend)
	);

	// R05 source 2 always edge, polarity from option
	irqc_edge_latch u_src2 (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.line(~src2_req),
		.rise_sel(src2_edge_polarity),
		.clr(clr_r[2]),
		.pend_r(src2_pend)
	);

	// R04 level mode reads the line directly
	assign src1_any = src1_level_select ? src1_req : src1_pend;

	// fixed priority pick of the request to take
	always @* begin
		// R01 maskable gated by enable, R20 no nesting
		mask_ok = global_irq_enable & ~inhib_r & (irq_mode_r == `IRQC_CTX_NORM);
		req_any = 1'b0;
		req_idx = 3'h0;
		// R21 nmi unless already in nmi
		if (nmi_pend && irq_mode_r != `IRQC_CTX_NMI) begin
			req_any = 1'b1;
			req_idx = 3'h0;
		// R20 source 1 highest maskable
		end else if (mask_ok && src1_any) begin
			req_any = 1'b1;
			req_idx = 3'h1;
		end else if (mask_ok && src2_pend) begin
			req_any = 1'b1;
			req_idx = 3'h2;
		// R06 sources 3 and 4 sampled as levels
		end else if (mask_ok && src3_req) begin
			req_any = 1'b1;
			req_idx = 3'h3;
		end else if (mask_ok && src4_req) begin
			req_any = 1'b1;
			req_idx = 3'h4;
		end
	end

	// R22 registered pending and index for the core
	always @(posedge ref_clk) begin
		if (!rstn) begin
			irq_pending_r <= 1'b0;
			irq_index_r <= 3'h0;
			wake_r <= 1'b0;
		end else begin
			irq_pending_r <= req_any & (state_r == ST_IDLE);
			irq_index_r <= req_idx;
			// R02 wake only with global enable set
			wake_r <= req_any & global_irq_enable;
		end
	end

	// next state of the entry sequence
	always @* begin
		state_nxt = state_r;
		case (state_r)
			// R09 take only at an instruction boundary
			ST_IDLE: begin
				if (core_boundary && irq_pending_r && !return_from_interrupt)
					state_nxt = ST_SWAP;
			end
			// R11 fixed order of entry steps
			ST_SWAP: state_nxt = ST_PUSH;
			ST_PUSH: state_nxt = ST_INHB;
			ST_INHB: state_nxt = ST_CLRL;
			ST_CLRL: state_nxt = ST_VECT;
			ST_VECT: state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
	end

	// vector address of the source being entered
	always @* begin
		case (take_idx_r)
			3'h0: vec_sel = `IRQC_VEC0;
			3'h1: vec_sel = `IRQC_VEC1;
			3'h2: vec_sel = `IRQC_VEC2;
			3'h3: vec_sel = `IRQC_VEC3;
			3'h4: vec_sel = `IRQC_VEC4;
			default: vec_sel = `IRQC_VEC4;
		endcase
	end

	// sequencer registers and one-cycle strobes
	always @(posedge ref_clk) begin
		if (!rstn) begin
			state_r <= ST_IDLE;
			take_idx_r <= 3'h0;
			anomaly_r <= 1'b0;
			inhib_r <= 1'b0;
			flag_sel_r <= `IRQC_CTX_NORM;
			irq_mode_r <= `IRQC_CTX_NORM;
			nmi_ret_mode_r <= `IRQC_CTX_NORM;
			nmi_ret_sel_r <= `IRQC_CTX_NORM;
			clr_r <= 3'h0;
			flag_swap_r <= 1'b0;
			pc_push_r <= 1'b0;
			pc_pop_r <= 1'b0;
			vec_load_r <= 1'b0;
			vec_addr_r <= 12'h000;
		end else begin
			state_r <= state_nxt;
			// strobes default low
			clr_r <= 3'h0;
			flag_swap_r <= 1'b0;
			pc_push_r <= 1'b0;
			pc_pop_r <= 1'b0;
			vec_load_r <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					if (state_nxt == ST_SWAP) begin
						// freeze the winner at the boundary
						take_idx_r <= irq_index_r;
						// R13 maskable during ldi window
						anomaly_r <= ldi_opt_window && irq_index_r != 3'h0 &&
							irq_mode_r == `IRQC_CTX_NORM;
					// R12 return restores previous context
					end else if (return_from_interrupt && irq_mode_r != `IRQC_CTX_NORM) begin
						pc_pop_r <= 1'b1;
						flag_swap_r <= 1'b1;
						if (irq_mode_r == `IRQC_CTX_NMI) begin
							irq_mode_r <= nmi_ret_mode_r;
							flag_sel_r <= nmi_ret_sel_r;
							inhib_r <= (nmi_ret_mode_r != `IRQC_CTX_NORM);
						end else begin
							irq_mode_r <= `IRQC_CTX_NORM;
							flag_sel_r <= `IRQC_CTX_NORM;
							inhib_r <= 1'b0;
						end
					end
				end
				// R10 switch flag set with the context
				ST_SWAP: begin
					if (take_idx_r == 3'h0) begin
						nmi_ret_mode_r <= irq_mode_r;
						nmi_ret_sel_r <= flag_sel_r;
						irq_mode_r <= `IRQC_CTX_NMI;
						flag_sel_r <= `IRQC_CTX_NMI;
						flag_swap_r <= 1'b1;
					end else begin
						irq_mode_r <= `IRQC_CTX_IRQ;
						// R13 flags stay on the normal pair
						if (!anomaly_r) begin
							flag_sel_r <= `IRQC_CTX_IRQ;
							flag_swap_r <= 1'b1;
						end
					end
				end
				// R11 counter to first stack level
				ST_PUSH: pc_push_r <= 1'b1;
				// R11 maskable lines inhibited
				ST_INHB: inhib_r <= 1'b1;
				// R07 clear the taken source latch
				ST_CLRL: begin
					if (take_idx_r <= 3'h2)
						clr_r <= 3'h1 << take_idx_r;
				end
				// R11 vector into the counter
				ST_VECT: begin
					vec_load_r <= 1'b1;
					vec_addr_r <= vec_sel;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// R10 banked carry and zero pairs
	irqc_flag_bank u_flags (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.sel(flag_sel_r),
		.wr(flag_wr),
		.c_in(flag_c_in),
		.z_in(flag_z_in),
		.c_r(carry_r),
		.z_r(zero_r)
	);

endmodule // irqc_top
`default_nettype wire

// [tb/irqc_top_props.sv]
/*
 * port checker for the interrupt request block.
 * assumes the core never returns while an entry is in flight.
 */
`default_nettype none
`include "irqc_regs.vh"

module irqc_top_props (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata_r,
	// core link
	input wire logic core_boundary,
	input wire logic return_from_interrupt,
	input wire logic ldi_opt_window,
	input wire logic irq_pending_r,
	input wire logic [2:0] irq_index_r,
	input wire logic wake_r,
	input wire logic flag_swap_r,
	input wire logic pc_push_r,
	input wire logic pc_pop_r,
	input wire logic vec_load_r,
	input wire logic [11:0] vec_addr_r,
	input wire logic [1:0] irq_mode_r
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	wire take = core_boundary && irq_pending_r && !return_from_interrupt; // entry taken
	logic gen_r, gen_d; // mirror of the enable bit, and one cycle later
	logic [2:0] busy_r; // entry still in flight
	// mirror the write-only enable, since it cannot be read back
	always @(posedge ref_clk) begin
		if (!rstn) begin
			gen_r <= 1'b0;
			gen_d <= 1'b0;
			busy_r <= 3'h0;
		end else begin
			if (reg_wr && reg_addr == `IRQC_OPT_ADDR) gen_r <= reg_wdata[`IRQC_GEN_BIT];
			gen_d <= gen_r;
			busy_r <= take ? 3'h6 : (busy_r != 3'h0 ? busy_r - 3'h1 : 3'h0);
		end
	end
	function automatic logic [11:0] vmap(input logic [2:0] k);
		return k == 3'h0 ? `IRQC_VEC0 : k == 3'h1 ? `IRQC_VEC1 : k == 3'h2 ? `IRQC_VEC2 :
			k == 3'h3 ? `IRQC_VEC3 : `IRQC_VEC4;
	endfunction
	sequence swap_s; ##[1:2] flag_swap_r; endsequence
	// push is seen three samples after the take, vector load three later
	sequence entry_s; ##3 pc_push_r ##3 vec_load_r; endsequence
	property vec_p;
		logic [2:0] k;
		(take, k = irq_index_r) |-> ##6 vec_addr_r == vmap(k);
	endproperty
	entry_order_a: assert property (take |-> entry_s)
		else $error("entry steps out of order");
	entry_swap_a: assert property (take && !ldi_opt_window |-> swap_s)
		else $error("flag set not switched on entry");
	vector_addr_a: assert property (vec_p)
		else $error("wrong vector for winning source");
	nmi_mode_a: assert property (take && irq_index_r == 3'h0 |-> ##2 irq_mode_r == `IRQC_CTX_NMI)
		else $error("nmi entry not in nmi mode");
	seq_busy_a: assert property (take |-> ##2 !irq_pending_r [*3])
		else $error("pending during entry");
	ret_pop_a: assert property (return_from_interrupt && busy_r == 3'h0 && irq_mode_r != 2'h0 |=> pc_pop_r && flag_swap_r)
		else $error("return without pop and swap");
	no_nesting_a: assert property (irq_mode_r == `IRQC_CTX_IRQ && irq_pending_r |-> irq_index_r == 3'h0)
		else $error("maskable nested in maskable");
	gen_off_a: assert property (!gen_r && !gen_d && irq_pending_r |-> irq_index_r == 3'h0)
		else $error("maskable taken while disabled");
	no_wake_a: assert property (!gen_r && !gen_d |-> !wake_r)
		else $error("wake while disabled");
	rdata_zero_a: assert property (reg_rd |=> reg_rdata_r == 8'h00)
		else $error("write-only register read nonzero");
endmodule // irqc_top_props

bind irqc_top irqc_top_props u_irqc_top_props (.*);
`default_nettype wire

// [tb/irqc_core_model.sv]
/*
 * core stand-in: instruction boundaries every fourth cycle and returns.
 * assumes the bench raises ret_cmd only once an entry has finished.
 */
`default_nettype none

module irqc_core_model (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// bench control
	input wire logic run,
	input wire logic ret_cmd,
	// block answers
	input wire logic irq_pending_r,
	input wire logic vec_load_r,
	// core strobes
	output logic core_boundary,
	output logic return_from_interrupt
);
	timeunit 1ns;
	timeprecision 1ps;
	logic busy_r; // entry in flight, no boundary meanwhile
	logic [1:0] cyc_r; // four-cycle instruction count
	always @(posedge ref_clk) begin
		if (!rstn) begin
			busy_r <= 1'b0;
			cyc_r <= 2'h0;
			core_boundary <= 1'b0;
			return_from_interrupt <= 1'b0;
		end else begin
			cyc_r <= cyc_r + 2'h1;
			core_boundary <= run && !busy_r && !ret_cmd && cyc_r == 2'h3;
			return_from_interrupt <= ret_cmd && !busy_r;
			if (core_boundary && irq_pending_r) busy_r <= 1'b1;
			else if (vec_load_r) busy_r <= 1'b0;
		end
	end
endmodule // irqc_core_model
`default_nettype wire

// [tb/tb.sv]
/*
 * self-checking bench for the interrupt request block.
 * assumes the core model file and the bound checker are compiled too.
 */
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// design ports
	logic ref_clk, rstn, reg_wr, reg_rd, nmi_pin_n, run, ret_cmd;
	logic [7:0] reg_addr, reg_wdata, reg_rdata_r, pa_pin, pb_pin, pc_pin, pa_opt, pa_dat, pb_opt, pb_dat, pc_opt, pc_dat;
	logic timer_zero_flag, timer_irq_mask, conv_done_flag, converter_irq_mask, reload_overflow_flag;
	logic reload_overflow_irq_mask, reload_compare_flag, reload_compare_irq_mask, reload_edge_flag;
	logic reload_edge_irq_mask, serial_running_flag, serial_irq_mask;
	logic core_boundary, return_from_interrupt, ldi_opt_window, flag_wr, flag_c_in, flag_z_in;
	logic irq_pending_r, wake_r, flag_swap_r, pc_push_r, pc_pop_r, vec_load_r, carry_r, zero_r;
	logic [2:0] irq_index_r;
	logic [11:0] vec_addr_r;
	logic [1:0] irq_mode_r;
	// bench model: context stack and flag banks
	int errors, checked, i, n, s1, s3, s4, pend, idx;
	logic [31:0] r, q;
	logic [1:0] mode_q[$];
	logic [1:0] bank[3];
	irqc_top u_irqc_top (.*);
	irqc_core_model u_irqc_core_model (.*);
	// free-running clock
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	task automatic complete_run;
		$display("checked=%0d errors=%0d", checked, errors);
		if (errors == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// read data stand from the cycle after the strobe and hold until the next read
	task automatic rd(input logic [7:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		chk(reg_rdata_r, 8'h00);
		@(posedge ref_clk);
	endtask
	// bounded wait for a vector load, then compare address and mode
	task automatic enter(input logic [11:0] v, input logic [1:0] m);
		i = 0;
		do begin
			@(negedge ref_clk);
			i++;
		end while (vec_load_r !== 1'b1 && i < 80);
		if (i >= 80) begin
			errors++;
			complete_run();
		end
		chk(vec_addr_r, v);
		chk(irq_mode_r, m);
		mode_q.push_back(m);
		@(posedge ref_clk);
	endtask
	task automatic ret;
		ret_cmd <= 1'b1;
		@(posedge ref_clk);
		ret_cmd <= 1'b0;
		void'(mode_q.pop_back());
		cyc(3);
		@(negedge ref_clk);
		chk(irq_mode_r, mode_q.size() > 0 ? mode_q[$] : 2'h0);
		@(posedge ref_clk);
	endtask
	task automatic quiet(input int k);
		repeat (k) begin
			@(negedge ref_clk);
			chk(vec_load_r, 1'b0);
		end
		@(posedge ref_clk);
	endtask
	// write the active flag pair and record it in the bench bank of the current mode
	task automatic fl(input logic c, input logic z);
		flag_wr <= 1'b1;
		flag_c_in <= c;
		flag_z_in <= z;
		@(posedge ref_clk);
		flag_wr <= 1'b0;
		bank[mode_q.size() > 0 ? mode_q[$] : 0] = {c, z};
	endtask
	task automatic chkf;
		cyc(2);
		@(negedge ref_clk);
		chk({carry_r, zero_r}, bank[mode_q.size() > 0 ? mode_q[$] : 0]);
		@(posedge ref_clk);
	endtask
	task automatic pulse_nmi;
		nmi_pin_n <= 1'b0;
		cyc(2);
		nmi_pin_n <= 1'b1;
	endtask
	initial begin
		errors = 0;
		checked = 0;
		bank = '{2'h0, 2'h0, 2'h0};
		{rstn, reg_wr, reg_rd, run, ret_cmd, ldi_opt_window, flag_wr, flag_c_in, flag_z_in} = 9'h000;
		{reg_addr, reg_wdata, pa_opt, pa_dat, pb_opt, pb_dat, pc_opt, pc_dat} = 64'h0;
		{nmi_pin_n, pa_pin, pb_pin, pc_pin} = 25'h1FFFFFF;
		{timer_zero_flag, timer_irq_mask, conv_done_flag, converter_irq_mask, reload_overflow_flag} = 5'h00;
		{reload_overflow_irq_mask, reload_compare_flag, reload_compare_irq_mask, reload_edge_flag} = 4'h0;
		{reload_edge_irq_mask, serial_running_flag, serial_irq_mask} = 3'h0;
		r = $urandom(35);
		repeat (16) @(posedge ref_clk);
		rstn <= 1'b1;
		cyc(2);
		rd(8'hC8);
		wr(8'h00, 8'hFF);
		rd(8'h00);
		// random sources with the core stalled: pending and winner
		for (n = 0; n < 16; n++) begin
			r = $urandom;
			q = $urandom;
			wr(8'hC8, q[10] ? 8'h50 : 8'h40);
			{pa_pin, pb_pin} <= r[15:0];
			pa_opt <= r[7:0] & r[23:16] & q[31:24];
			pb_opt <= r[31:24] & q[23:16] & r[15:8];
			{pa_dat, pb_dat} <= {q[23:16], r[31:24]};
			{timer_zero_flag, timer_irq_mask, conv_done_flag, converter_irq_mask} <= q[3:0];
			{reload_overflow_flag, reload_overflow_irq_mask, reload_compare_flag} <= q[6:4];
			{reload_compare_irq_mask, reload_edge_flag, reload_edge_irq_mask} <= q[9:7];
			cyc(6);
			@(negedge ref_clk);
			s1 = ((~pa_pin & pa_opt & pa_dat) | (~pb_pin & pb_opt & pb_dat)) != 8'h00;
			s3 = (reload_overflow_flag & reload_overflow_irq_mask) | (reload_compare_flag & reload_compare_irq_mask) |
				(reload_edge_flag & reload_edge_irq_mask);
			s4 = (timer_zero_flag & timer_irq_mask) | (conv_done_flag & converter_irq_mask);
			pend = q[10] && (s1 || s3 || s4);
			idx = s1 ? 1 : (s3 ? 3 : 4);
			chk(irq_pending_r, pend[0]);
			chk(wake_r, pend[0]);
			if (pend) chk(irq_index_r, idx[2:0]);
			@(posedge ref_clk);
		end
		{pa_opt, pb_opt} <= 16'h0;
		{timer_irq_mask, converter_irq_mask, reload_overflow_irq_mask} <= 3'h0;
		{reload_compare_irq_mask, reload_edge_irq_mask} <= 2'h0;
		// level source 1, nmi over it, banked flags
		wr(8'hC8, 8'h50);
		fl(1'b1, 1'b0);
		{pa_opt, pa_dat, pa_pin} <= 24'h0101FE;
		run <= 1'b1;
		enter(12'hFF6, 2'h1);
		pa_pin <= 8'hFF;
		fl(1'b1, 1'b1);
		pulse_nmi();
		enter(12'hFFC, 2'h2);
		chkf();
		ret();
		chkf();
		ret();
		chkf();
		// enable cleared: only the nmi gets through
		wr(8'hC8, 8'h40);
		{reload_overflow_flag, reload_overflow_irq_mask} <= 2'h3;
		quiet(12);
		pulse_nmi();
		enter(12'hFFC, 2'h2);
		ret();
		quiet(12);
		reload_overflow_flag <= 1'b0;
		// source 2 falling, two events kept as one
		wr(8'hC8, 8'h10);
		run <= 1'b0;
		serial_irq_mask <= 1'b1;
		repeat (2) begin
			serial_running_flag <= 1'b1;
			cyc(2);
			serial_running_flag <= 1'b0;
			cyc(4);
		end
		run <= 1'b1;
		enter(12'hFF4, 2'h1);
		ret();
		quiet(16);
		// source 2 rising: port C pin request counts on release
		wr(8'hC8, 8'h30);
		{pc_opt, pc_dat, pc_pin} <= 24'h0101FE;
		quiet(12);
		pc_pin <= 8'hFF;
		enter(12'hFF4, 2'h1);
		ret();
		// source 1 edge mode keeps a short pulse, level mode loses it
		for (n = 0; n < 2; n++) begin
			wr(8'hC8, n ? 8'h50 : 8'h10);
			run <= 1'b0;
			pa_pin <= 8'hFE;
			cyc(3);
			pa_pin <= 8'hFF;
			cyc(4);
			run <= 1'b1;
			if (n == 0) enter(12'hFF6, 2'h1);
			if (n == 0) ret();
			else quiet(16);
		end
		// timer onto vector 4, reload edge onto vector 3
		wr(8'hC8, 8'h10);
		{timer_zero_flag, timer_irq_mask} <= 2'h3;
		enter(12'hFF0, 2'h1);
		timer_zero_flag <= 1'b0;
		ret();
		{reload_edge_flag, reload_edge_irq_mask} <= 2'h3;
		enter(12'hFF2, 2'h1);
		reload_edge_flag <= 1'b0;
		ret();
		// maskable taken inside the ldi window keeps the normal flag pair
		ldi_opt_window <= 1'b1;
		timer_zero_flag <= 1'b1;
		enter(12'hFF0, 2'h1);
		{timer_zero_flag, ldi_opt_window} <= 2'h0;
		cyc(2);
		@(negedge ref_clk);
		chk({carry_r, zero_r}, bank[0]);
		@(posedge ref_clk);
		ret();
		complete_run();
	end
endmodule // tb
`default_nettype wire
